// ---- rcbau_bcd_adder.sv ----
`default_nettype none
module rcbau_bcd_adder #(
    parameter int DIGITS = rcbau_pkg::BCD_DIGITS
) (
    // Addends
    input wire logic [rcbau_pkg::DIGIT_W*DIGITS-1:0] a,
    input wire logic [rcbau_pkg::DIGIT_W*DIGITS-1:0] b,
    // Result
    output logic [rcbau_pkg::DIGIT_W*DIGITS-1:0] sum,
    output logic [DIGITS-1:0] carry,
    output logic bad_digit
);
    import rcbau_pkg::*;

    logic [DIGITS:0] chain;
    logic [DIGITS-1:0] bad;

    assign chain[0] = 1'b0;
    assign carry = chain[DIGITS:1];
    assign bad_digit = |bad;

    for (genvar g = 0; g < DIGITS; g++) begin : g_digit
        logic [DIGIT_W:0] raw;
        logic [DIGIT_W:0] fixed;
        logic adj;
        assign raw = {1'b0, a[g*DIGIT_W +: DIGIT_W]} + {1'b0, b[g*DIGIT_W +: DIGIT_W]}
            + {{DIGIT_W{1'b0}}, chain[g]};
        assign adj = raw > BCD_DIGIT_MAX;
        assign fixed = adj ? raw + BCD_ADJUST : raw;
        assign sum[g*DIGIT_W +: DIGIT_W] = fixed[DIGIT_W-1:0];
        assign chain[g+1] = adj;
        // Either addend digit above nine poisons the whole sum
        assign bad[g] = ({1'b0, a[g*DIGIT_W +: DIGIT_W]} > BCD_DIGIT_MAX)
            || ({1'b0, b[g*DIGIT_W +: DIGIT_W]} > BCD_DIGIT_MAX);
    end
endmodule
`default_nettype wire

// ---- rcbau_pkg.sv ----
`default_nettype none
package rcbau_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int HALF_W = 16;
    localparam int DIGIT_W = 4;
    localparam int BCD_DIGITS = 8;
    localparam int HALF_DIGITS = 4;
    localparam int IRQ_W = 3;
    localparam int FLAG_W = 10;

    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_ACC = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_OPND_LO = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_OPND_HI = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h18;

    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_OP_LSB = 1;
    localparam int CTRL_SRC_LSB = 3;
    localparam int CTRL_PTR_OK_BIT = 5;

    localparam int FLG_LT = 0;
    localparam int FLG_EQ = 1;
    localparam int FLG_GT = 2;
    localparam int FLG_ZERO = 3;
    localparam int FLG_C16 = 4;
    localparam int FLG_C32 = 5;
    localparam int FLG_NEG = 6;
    localparam int FLG_BAD_PTR = 7;
    localparam int FLG_BAD_NUM = 8;
    localparam int FLG_BUSY = 9;

    localparam int IRQ_DONE = 0;
    localparam int IRQ_BAD_PTR = 1;
    localparam int IRQ_BAD_NUM = 2;

    localparam int FP_SIGN = 31;
    localparam int FP_EXP_LSB = 23;
    localparam int FP_EXP_W = 8;
    localparam int FP_MAN_W = 23;
    localparam logic [FP_EXP_W-1:0] FP_EXP_ALL = 8'hff;

    localparam logic [DIGIT_W:0] BCD_DIGIT_MAX = 5'h09;
    localparam logic [DIGIT_W:0] BCD_ADJUST = 5'h06;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        OP_REAL_LOAD,
        OP_REAL_COMPARE,
        OP_BCD_SUM,
        OP_BCD_SUM_DOUBLE
    } rcbau_op_t;

    typedef enum logic [1:0] {
        SRC_DIRECT,
        SRC_POINTER,
        SRC_CONST,
        SRC_SPARE
    } rcbau_src_t;
endpackage
`default_nettype wire

// ---- rcbau_properties.sv ----
`default_nettype none
module rcbau_properties
    import rcbau_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write side
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Read side
    input wire logic [rcbau_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [rcbau_pkg::DATA_W-1:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Interrupt
    input wire logic irq
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable({s_axi_rresp, s_axi_rdata});
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data changed early");
    property p_rd_answer;
        s_rd_take |=> s_axi_rvalid;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    property p_arready;
        s_axi_arready == !s_axi_rvalid;
    endproperty
    a_arready: assert property (p_arready) else $error("read address ready wrong");
    property p_wr_answer;
        s_wr_both ##0 !s_axi_bvalid |-> ##2 s_axi_bvalid;
    endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("write not answered");
    property p_b_cause;
        $rose(s_axi_bvalid) |->
            $past((s_axi_awvalid && s_axi_awready) || (s_axi_wvalid && s_axi_wready), 2);
    endproperty
    a_b_cause: assert property (p_b_cause) else $error("response without write");
    property p_r_close;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    a_r_close: assert property (p_r_close) else $error("read data repeated");
    property p_flags_read;
        s_rd_take ##0 (s_axi_araddr == OFS_FLAGS) |=>
            s_axi_rdata[31:10] == 22'h0 && $countones(s_axi_rdata[2:0]) <= 1;
    endproperty
    a_flags_read: assert property (p_flags_read) else $error("compare flags not one-hot");
    property p_unmapped;
        s_rd_take ##0 (s_axi_araddr > OFS_IRQ_MASK) |=>
            s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
    property p_irq_reset;
        $rose(aresetn) |-> !irq;
    endproperty
    a_irq_reset: assert property (p_irq_reset) else $error("interrupt high after reset");
endmodule
bind rcbau_unit rcbau_properties u_rcbau_properties (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq));
`default_nettype wire

// ---- rcbau_unit.sv ----
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`default_nettype none
module rcbau_unit (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [rcbau_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [rcbau_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [rcbau_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [rcbau_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Interrupt
    output logic irq
);
    import rcbau_pkg::*;

    typedef enum logic {
        ST_IDLE,
        ST_EXEC
    } rcbau_state_t;

    // Bus handshake state
    logic aw_full_reg, aw_full_next;
    logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
    logic w_full_reg, w_full_next;
    logic [DATA_W-1:0] w_data_reg, w_data_next;
    logic [3:0] w_strb_reg, w_strb_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic rvalid_reg, rvalid_next;
    logic [DATA_W-1:0] rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next;

    // Datapath state
    rcbau_state_t state_reg, state_next;
    rcbau_op_t op_reg, op_next;
    rcbau_src_t src_reg, src_next;
    logic ptr_ok_reg, ptr_ok_next;
    logic [DATA_W-1:0] acc_reg, acc_next;
    logic [HALF_W-1:0] opnd_lo_reg, opnd_lo_next;
    logic [HALF_W-1:0] opnd_hi_reg, opnd_hi_next;
    logic [FLAG_W-1:0] flags_reg, flags_next;
    logic [IRQ_W-1:0] irq_stat_reg, irq_stat_next;
    logic [IRQ_W-1:0] irq_mask_reg, irq_mask_next;

    logic wr_fire;
    logic [DATA_W-1:0] ctrl_image;
    logic [DATA_W-1:0] ctrl_merged;
    logic [DATA_W-1:0] rd_word;
    logic rd_hit;
    logic [DATA_W-1:0] opnd;
    logic [DATA_W-1:0] add_a;
    logic [DATA_W-1:0] add_b;
    logic [DATA_W-1:0] add_sum;
    logic [BCD_DIGITS-1:0] add_carry;
    logic add_bad;
    logic [IRQ_W-1:0] events;

    function automatic logic [DATA_W-1:0] merge_bytes(
        input logic [DATA_W-1:0] old_w,
        input logic [DATA_W-1:0] new_w,
        input logic [3:0] strb
    );
        logic [DATA_W-1:0] res;
        res = old_w;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Only NaN is rejected; infinities order normally
    function automatic logic is_not_real(input logic [DATA_W-1:0] v);
        return (v[FP_EXP_LSB +: FP_EXP_W] == FP_EXP_ALL)
            && (v[FP_MAN_W-1:0] != '0);
    endfunction

    // Returns {gt, eq, lt}, always one-hot
    function automatic logic [2:0] real_order(
        input logic [DATA_W-1:0] x,
        input logic [DATA_W-1:0] y
    );
        logic [DATA_W-2:0] mx;
        logic [DATA_W-2:0] my;
        logic both_zero;
        mx = x[DATA_W-2:0];
        my = y[DATA_W-2:0];
        both_zero = (mx == '0) && (my == '0);
        if (both_zero || x == y) begin
            return 3'h2;
        end else if (x[FP_SIGN] != y[FP_SIGN]) begin
            return y[FP_SIGN] ? 3'h4 : 3'h1;
        end else if ((mx > my) ^ x[FP_SIGN]) begin
            return 3'h4;
        end else begin
            return 3'h1;
        end
    endfunction

    assign s_axi_awready = !aw_full_reg;
    assign s_axi_wready = !w_full_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign irq = |(irq_stat_reg & irq_mask_reg);

    // Address and data may arrive in either order; answer once both are held
    assign wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;

    assign ctrl_image = {{(DATA_W-6){1'b0}}, ptr_ok_reg, src_reg, op_reg, 1'b0};
    assign ctrl_merged = merge_bytes(ctrl_image, w_data_reg, w_strb_reg);
    assign opnd = {opnd_hi_reg, opnd_lo_reg};

    // Read decode
    always_comb begin
        rd_word = '0;
        rd_hit = 1'b1;
        if (s_axi_araddr == OFS_CTRL) begin
            rd_word = ctrl_image;
        end else if (s_axi_araddr == OFS_ACC) begin
            rd_word = acc_reg;
        end else if (s_axi_araddr == OFS_OPND_LO) begin
            rd_word = {{HALF_W{1'b0}}, opnd_lo_reg};
        end else if (s_axi_araddr == OFS_OPND_HI) begin
            rd_word = {{HALF_W{1'b0}}, opnd_hi_reg};
        end else if (s_axi_araddr == OFS_FLAGS) begin
            rd_word = {{(DATA_W-FLAG_W){1'b0}}, flags_reg};
        end else if (s_axi_araddr == OFS_IRQ_STAT) begin
            rd_word = {{(DATA_W-IRQ_W){1'b0}}, irq_stat_reg};
        end else if (s_axi_araddr == OFS_IRQ_MASK) begin
            rd_word = {{(DATA_W-IRQ_W){1'b0}}, irq_mask_reg};
        end else begin
            rd_hit = 1'b0;
        end
    end

    // Bus group next state
    always_comb begin
        aw_full_next = aw_full_reg;
        aw_addr_next = aw_addr_reg;
        w_full_next = w_full_reg;
        w_data_next = w_data_reg;
        w_strb_next = w_strb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (s_axi_awvalid && !aw_full_reg) begin
            aw_full_next = 1'b1;
            aw_addr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_full_reg) begin
            w_full_next = 1'b1;
            w_data_next = s_axi_wdata;
            w_strb_next = s_axi_wstrb;
        end
        if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        if (wr_fire) begin
            aw_full_next = 1'b0;
            w_full_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = RESP_OKAY;
            if (aw_addr_reg != OFS_CTRL && aw_addr_reg != OFS_ACC
                && aw_addr_reg != OFS_OPND_LO && aw_addr_reg != OFS_OPND_HI
                && aw_addr_reg != OFS_FLAGS && aw_addr_reg != OFS_IRQ_STAT
                && aw_addr_reg != OFS_IRQ_MASK) begin
                bresp_next = RESP_SLVERR;
            end
        end
        if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
        if (s_axi_arvalid && !rvalid_reg) begin
            rvalid_next = 1'b1;
            rdata_next = rd_word;
            rresp_next = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_full_reg <= 1'b0;
            w_data_reg <= '0;
            w_strb_reg <= '0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= RESP_OKAY;
        end else begin
            aw_full_reg <= aw_full_next;
            aw_addr_reg <= aw_addr_next;
            w_full_reg <= w_full_next;
            w_data_reg <= w_data_next;
            w_strb_reg <= w_strb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end

    // One adder serves both widths; the short form sees zero upper digits
    assign add_a = (op_reg == OP_BCD_SUM) ? {{HALF_W{1'b0}}, acc_reg[HALF_W-1:0]} : acc_reg;
    assign add_b = (op_reg == OP_BCD_SUM) ? {{HALF_W{1'b0}}, opnd_lo_reg} : opnd;

    rcbau_bcd_adder #(
        .DIGITS(BCD_DIGITS)
    ) u_adder (
        .a(add_a),
        .b(add_b),
        .sum(add_sum),
        .carry(add_carry),
        .bad_digit(add_bad)
    );

    // Datapath group next state
    always_comb begin
        logic bad_ptr;
        logic [2:0] order;
        logic [DATA_W-1:0] res;
        logic [DATA_W-1:0] merged;
        bad_ptr = (src_reg == SRC_POINTER) && !ptr_ok_reg;
        order = real_order(acc_reg, opnd);
        res = '0;
        merged = merge_bytes(acc_reg, w_data_reg, w_strb_reg);
        state_next = state_reg;
        op_next = op_reg;
        src_next = src_reg;
        ptr_ok_next = ptr_ok_reg;
        acc_next = acc_reg;
        opnd_lo_next = opnd_lo_reg;
        opnd_hi_next = opnd_hi_reg;
        flags_next = flags_reg;
        irq_mask_next = irq_mask_reg;
        events = '0;
        // Writes other than to OFS_IRQ_STAT are dropped while an instruction executes so operands stay still
        if (wr_fire && state_reg == ST_IDLE) begin
            if (aw_addr_reg == OFS_CTRL) begin
                op_next = rcbau_op_t'(ctrl_merged[CTRL_OP_LSB +: 2]);
                src_next = rcbau_src_t'(ctrl_merged[CTRL_SRC_LSB +: 2]);
                ptr_ok_next = ctrl_merged[CTRL_PTR_OK_BIT];
                if (ctrl_merged[CTRL_START_BIT]) begin
                    state_next = ST_EXEC;
                end
            end else if (aw_addr_reg == OFS_ACC) begin
                acc_next = merged;
            end else if (aw_addr_reg == OFS_OPND_LO) begin
                merged = merge_bytes(DATA_W'(opnd_lo_reg), w_data_reg, w_strb_reg);
                opnd_lo_next = merged[HALF_W-1:0];
            end else if (aw_addr_reg == OFS_OPND_HI) begin
                merged = merge_bytes(DATA_W'(opnd_hi_reg), w_data_reg, w_strb_reg);
                opnd_hi_next = merged[HALF_W-1:0];
            end else if (aw_addr_reg == OFS_IRQ_MASK) begin
                merged = merge_bytes(DATA_W'(irq_mask_reg), w_data_reg, w_strb_reg);
                irq_mask_next = merged[IRQ_W-1:0];
            end
        end
        if (state_reg == ST_EXEC) begin
            state_next = ST_IDLE;
            events[IRQ_DONE] = 1'b1;
            // Each instruction rewrites only the flags it owns
            case (op_reg)
                OP_REAL_LOAD: begin
                    flags_next[FLG_BAD_PTR] = bad_ptr;
                    if (!bad_ptr) begin
                        acc_next = opnd;
                    end
                end
                OP_REAL_COMPARE: begin
                    flags_next[FLG_BAD_PTR] = bad_ptr;
                    flags_next[FLG_BAD_NUM] = !bad_ptr
                        && (is_not_real(acc_reg) || is_not_real(opnd));
                    if (!bad_ptr && !flags_next[FLG_BAD_NUM]) begin
                        flags_next[FLG_LT] = order[0];
                        flags_next[FLG_EQ] = order[1];
                        flags_next[FLG_GT] = order[2];
                    end
                end
                default: begin
                    // Constant source on the short add is a program error; read as direct
                    flags_next[FLG_BAD_PTR] = bad_ptr;
                    flags_next[FLG_BAD_NUM] = !bad_ptr && add_bad;
                    if (!bad_ptr && !add_bad) begin
                        if (op_reg == OP_BCD_SUM) begin
                            res = {{HALF_W{1'b0}}, add_sum[HALF_W-1:0]};
                            flags_next[FLG_C32] = 1'b0;
                        end else begin
                            res = add_sum;
                            flags_next[FLG_C32] = add_carry[BCD_DIGITS-1];
                        end
                        acc_next = res;
                        flags_next[FLG_C16] = add_carry[HALF_DIGITS-1];
                        flags_next[FLG_ZERO] = (res == '0);
                        flags_next[FLG_NEG] = res[DATA_W-1];
                    end
                end
            endcase
            events[IRQ_BAD_PTR] = flags_next[FLG_BAD_PTR];
            events[IRQ_BAD_NUM] = flags_next[FLG_BAD_NUM]
                && op_reg != OP_REAL_LOAD;
        end
        flags_next[FLG_BUSY] = (state_next == ST_EXEC);
        irq_stat_next = irq_stat_reg;
        if (wr_fire && aw_addr_reg == OFS_IRQ_STAT) begin
            merged = merge_bytes('0, w_data_reg, w_strb_reg);
            irq_stat_next = irq_stat_reg & ~merged[IRQ_W-1:0];
        end
        // A new event wins over a clear in the same cycle
        irq_stat_next = irq_stat_next | events;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= ST_IDLE;
            op_reg <= OP_REAL_LOAD;
            src_reg <= SRC_DIRECT;
            ptr_ok_reg <= 1'b0;
            acc_reg <= '0;
            opnd_lo_reg <= '0;
            opnd_hi_reg <= '0;
            flags_reg <= '0;
            irq_stat_reg <= '0;
            irq_mask_reg <= '0;
        end else begin
            state_reg <= state_next;
            op_reg <= op_next;
            src_reg <= src_next;
            ptr_ok_reg <= ptr_ok_next;
            acc_reg <= acc_next;
            opnd_lo_reg <= opnd_lo_next;
            opnd_hi_reg <= opnd_hi_next;
            flags_reg <= flags_next;
            irq_stat_reg <= irq_stat_next;
            irq_mask_reg <= irq_mask_next;
        end
    end
endmodule
`default_nettype wire

// ---- testbench.sv ----
`default_nettype none
module testbench
    import rcbau_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {string n; logic [33:0] v;} rcbau_exp_t;
    localparam logic [1:0] CMP = OP_REAL_COMPARE;
    localparam logic [1:0] S16 = OP_BCD_SUM;
    localparam logic [1:0] S32 = OP_BCD_SUM_DOUBLE;
    localparam logic [1:0] DIR = SRC_DIRECT;
    localparam logic [1:0] PTR = SRC_POINTER;
    localparam logic [1:0] CON = SRC_CONST;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [7:0] awaddr = 8'h0;
    logic [7:0] araddr = 8'h0;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'h0;
    logic wvalid = 1'h0;
    logic bready = 1'h0;
    logic arvalid = 1'h0;
    logic rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, a, b;
    logic [33:0] s;
    logic [9:0] flg;
    int seed = 32'h4e5e;
    int errors = 0;
    int checks = 0;
    int cycles = 0;
    rcbau_exp_t exp_q[$];
    rcbau_exp_t e;

    rcbau_unit u_rcbau_unit (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq));

    initial begin
        forever #12.5 aclk = ~aclk;
    end

    task automatic chk(input string n, input logic [33:0] ev, input logic [33:0] g);
        checks++;
        if (g !== ev) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, ev, g);
        end
    endtask

    task automatic close_out();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Watcher: each B or R response handshake retires the oldest expectation
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            errors++;
            close_out();
        end else if ((bvalid && bready) || (rvalid && rready)) begin
            e = exp_q.pop_front();
            chk(e.n, e.v, bvalid ? {bresp, 32'h0} : {rresp, rdata});
        end
    end

    // Ready raised late so the slave must hold its answer a cycle
    task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] r);
        exp_q.push_back('{"bresp", {r, 32'h0}});
        awaddr <= ad;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
            if (bvalid && !bready) bready <= 1'h1;
        end while (!(bvalid && bready));
        bready <= 1'h0;
    endtask

    task automatic rd(input string n, input logic [7:0] ad, input logic [33:0] ev);
        exp_q.push_back('{n, ev});
        araddr <= ad;
        arvalid <= 1'h1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'h0;
            if (rvalid && !rready) rready <= 1'h1;
        end while (!(rvalid && rready));
        rready <= 1'h0;
    endtask

    task automatic run(input logic [1:0] op, input logic [1:0] src, input logic ok,
            input logic [31:0] acc, input logic [31:0] opnd, input logic [31:0] e_acc,
            input logic [9:0] e_flg);
        wr(OFS_ACC, acc, RESP_OKAY);
        wr(OFS_OPND_LO, {16'h0, opnd[15:0]}, RESP_OKAY);
        wr(OFS_OPND_HI, {16'h0, opnd[31:16]}, RESP_OKAY);
        wr(OFS_CTRL, {26'h0, ok, src, op, 1'h1}, RESP_OKAY);
        rd("acc", OFS_ACC, {RESP_OKAY, e_acc});
        rd("flags", OFS_FLAGS, {RESP_OKAY, 22'h0, e_flg});
        flg = e_flg;
    endtask

    function automatic logic [33:0] bcd_add(input logic [31:0] x, input logic [31:0] y);
        logic [4:0] d;
        logic c;
        logic c16;
        logic [31:0] r;
        c = 1'h0;
        c16 = 1'h0;
        for (int k = 0; k < 8; k++) begin
            d = x[4*k+:4] + y[4*k+:4] + c;
            c = d > 5'h09;
            if (c) d = d + 5'h06;
            r[4*k+:4] = d[3:0];
            if (k == 3) c16 = c;
        end
        return {c, c16, r};
    endfunction

    function automatic logic [31:0] rbcd();
        logic [31:0] v;
        for (int k = 0; k < 8; k++) v[4*k+:4] = 4'({$random(seed)} % 32'ha);
        return v;
    endfunction

    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        rd("acc", OFS_ACC, {RESP_OKAY, 32'h0});
        rd("flags", OFS_FLAGS, {RESP_OKAY, 32'h0});
        rd("mask", OFS_IRQ_MASK, {RESP_OKAY, 32'h0});
        rd("unmapped", 8'h1c, {RESP_SLVERR, 32'h0});
        $display("test reset done");
        run(CMP, DIR, 1'h1, 32'h40e00000, 32'h40c00000, 32'h40e00000, 10'h004);
        run(CMP, CON, 1'h1, 32'h40c00000, 32'h40e00000, 32'h40c00000, 10'h001);
        run(CMP, DIR, 1'h1, 32'h00000000, 32'h80000000, 32'h00000000, 10'h002);
        run(CMP, DIR, 1'h1, 32'h3f800000, 32'h7fc00000, 32'h3f800000, 10'h102);
        run(CMP, PTR, 1'h0, 32'h3f800000, 32'h3f800000, 32'h3f800000, 10'h082);
        run(CMP, PTR, 1'h1, 32'hbf800000, 32'h3f800000, 32'hbf800000, 10'h001);
        $display("test compare done");
        run(S16, DIR, 1'h1, 32'h12349999, 32'h00000001, 32'h00000000, 10'h019);
        run(S16, PTR, 1'h1, 32'h00000456, 32'h00000544, 32'h00001000, 10'h001);
        run(S32, CON, 1'h1, 32'h99999999, 32'h00000001, 32'h00000000, 10'h039);
        run(S32, DIR, 1'h1, 32'h45000000, 32'h40000000, 32'h85000000, 10'h041);
        run(S32, DIR, 1'h1, 32'h12345678, 32'h0000000a, 32'h12345678, 10'h141);
        run(S16, DIR, 1'h1, 32'h0000000b, 32'h00000001, 32'h0000000b, 10'h141);
        run(OP_REAL_LOAD, DIR, 1'h1, 32'h0, 32'h40e00000, 32'h40e00000, 10'h141);
        for (int i = 0; i < 6; i++) begin
            a = rbcd();
            b = rbcd();
            s = bcd_add(a, b);
            run(S32, DIR, 1'h1, a, b, s[31:0], {3'h0, s[31], s[33:32], s[31:0] == 32'h0, 3'h1});
        end
        $display("test bcd done");
        rd("stat", OFS_IRQ_STAT, {RESP_OKAY, 32'h7});
        wr(OFS_IRQ_MASK, 32'h2, RESP_OKAY);
        chk("irq", {33'h0, 1'h1}, {33'h0, irq});
        wr(OFS_IRQ_STAT, 32'h2, RESP_OKAY);
        chk("irq", {33'h0, 1'h0}, {33'h0, irq});
        rd("stat", OFS_IRQ_STAT, {RESP_OKAY, 32'h5});
        wr(OFS_IRQ_MASK, 32'h7, RESP_OKAY);
        chk("irq", {33'h0, 1'h1}, {33'h0, irq});
        wr(OFS_IRQ_STAT, 32'h7, RESP_OKAY);
        chk("irq", {33'h0, 1'h0}, {33'h0, irq});
        wr(OFS_FLAGS, 32'h3ff, RESP_OKAY);
        rd("flags", OFS_FLAGS, {RESP_OKAY, 22'h0, flg});
        wr(8'h1c, 32'h1, RESP_SLVERR);
        $display("test irq and map done");
        close_out();
    end
endmodule
`default_nettype wire
